// >>> logic/stt_pkg.sv
// package: register map, field layout, reset values and carriers of the tick timer
package stt_pkg;

  // register byte offsets
  localparam logic [7:0] STT_OFF_CTRL_STATUS = 8'h00;  // tick_control_status
  localparam logic [7:0] STT_OFF_RELOAD      = 8'h04;  // reload_value
  localparam logic [7:0] STT_OFF_CURRENT     = 8'h08;  // current_count_value
  localparam logic [7:0] STT_OFF_CLK_SEL_0   = 8'h0C;  // clock_select_register_0
  localparam logic [7:0] STT_OFF_IRQ_STATUS  = 8'h10;  // sticky event status, read only
  localparam logic [7:0] STT_OFF_IRQ_CLEAR   = 8'h14;  // write one to clear, write only
  localparam logic [7:0] STT_OFF_IRQ_ENABLE  = 8'h18;  // interrupt enable

  // tick_control_status field positions
  localparam int STT_BIT_ENABLE    = 0;   // counter enable
  localparam int STT_BIT_TICK_INT  = 1;   // timer interrupt enable control
  localparam int STT_BIT_CLK_SRC   = 2;   // 1: processor clock, 0: external tick clock
  localparam int STT_BIT_ZERO_FLAG = 16;  // zero_reached_flag, clears on read

  // clock_select_register_0 field positions
  localparam int STT_CORE_SEL_LSB = 0;  // core clock select, bits 2:0
  localparam int STT_EXT_SEL_LSB  = 3;  // tick_external_clock_select, bits 5:3

  // status / enable / clear bit of the zero event
  localparam int STT_BIT_IRQ_ZERO = 0;

  // sizes and counts
  localparam int         STT_CNT_W      = 24;    // counter width
  localparam int         STT_SEL_W      = 3;     // select field width
  localparam int         STT_NUM_SRC    = 5;     // sources per clock selector
  localparam logic [2:0] STT_SEL_LIMIT  = 3'h5;  // first reserved select code

  // bus request carrier
  typedef struct packed {
    logic        wr;     // one-cycle write strobe
    logic        rd;     // one-cycle read strobe
    logic [7:0]  addr;   // byte address
    logic [31:0] wdata;  // write data
  } stt_bus_req_t;

  // whole state of the timer
  typedef struct packed {
    logic                 enable;      // counter running
    logic                 tick_int;    // interrupt enable control
    logic                 clk_src;     // clock source choice
    logic                 zero_flag;   // zero reached since last read
    logic [STT_CNT_W-1:0] reload;      // reload value
    logic [STT_CNT_W-1:0] count;       // current count
    logic [STT_SEL_W-1:0] ext_sel;     // external tick source select
    logic [STT_SEL_W-1:0] core_sel;    // core clock source select
    logic                 ext_prev;    // selected source, last cycle
    logic                 irq_status;  // sticky zero event
    logic                 irq_enable;  // interrupt mask
    logic [31:0]          rdata;       // read data, one cycle after strobe
  } stt_state_t;

  // value of the state after reset
  localparam stt_state_t STT_STATE_RESET = '0;

endpackage : stt_pkg

// >>> logic/stt_system_tick_timer.sv
// module: 24-bit decrementing system tick timer with register port and interrupt
// Function
// - 24-bit counter decrements each enabled tick
// - current value write clears counter to zero
// - reaches zero, reloads next tick, continues
// - zero_reached_flag set on transition to zero
// - reading control/status clears zero_reached_flag
// - current value unknown after reset allowed
// - reload of zero holds counter at zero
// - control bit 2 picks processor or external
// - clock select 0 bits 5:3 pick external
// - clock select 0 bits 2:0 pick core
//
// Our own choices: the register addresses and the address-and-strobe port.
module stt_system_tick_timer
  import stt_pkg::*;
(
  input  wire logic                 clk_i,              // processor clock, 100 MHz
  input  wire logic                 rst_i,              // async reset, active high
  input  wire stt_bus_req_t         bus_i,              // register port request
  output logic        [31:0]        rdata_o,            // read data, cycle after strobe
  input  wire logic [STT_NUM_SRC-1:0] ext_src_i,        // external tick clock sources
  output logic [STT_SEL_W-1:0]      core_clock_select_o, // core clock source select
  output logic [STT_CNT_W-1:0]      count_o,            // current count
  output logic                      irq_o               // level interrupt
);

  // state, its next value and helpers
  stt_state_t state_reg;   // registered state
  stt_state_t state_next;  // next state
  logic       ext_level;   // selected external source level
  logic       tick;        // one count step this cycle
  logic       cur_wr;      // write to current value
  logic       ctrl_rd;     // read of control/status
  logic       zero_evt;    // counter moves to zero this cycle
  logic       step;        // counter updated by a tick

  // address compare, shared by read and write decode
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction : hit

  // pick one of the external sources; reserved codes give a still level
  function automatic logic pick_src(input logic [STT_NUM_SRC-1:0] src,
                                    input logic [STT_SEL_W-1:0]   sel);
    logic res;
    res = 1'b0;
    if (sel < STT_SEL_LIMIT) begin
      res = src[sel];
    end
    pick_src = res;
  endfunction : pick_src

  // select code accepted only when it names one of five sources
  function automatic logic sel_ok(input logic [STT_SEL_W-1:0] sel);
    sel_ok = (sel < STT_SEL_LIMIT);
  endfunction : sel_ok

  // tick source and bus decode
  always_comb begin
    ext_level = pick_src(ext_src_i, state_reg.ext_sel);
    // processor clock ticks every cycle, external one on rising edge
    if (state_reg.clk_src) begin
      tick = 1'b1;
    end else begin
      tick = ext_level & ~state_reg.ext_prev;
    end
    cur_wr   = bus_i.wr & hit(bus_i.addr, STT_OFF_CURRENT);
    ctrl_rd  = bus_i.rd & hit(bus_i.addr, STT_OFF_CTRL_STATUS);
    step     = state_reg.enable & tick & ~cur_wr;
    // only a count from one reaches zero; a zero reload stays put
    zero_evt = step & (state_reg.count == 24'h000001);
  end

  // next-state logic
  always_comb begin
    state_next          = state_reg;
    state_next.ext_prev = ext_level;

    // counter: clear on write, reload at zero, else decrement
    if (cur_wr) begin
      state_next.count = '0;
    end else if (step) begin
      if (state_reg.count == 24'h000000) begin
        state_next.count = state_reg.reload;
      end else begin
        state_next.count = state_reg.count - 24'h000001;
      end
    end

    // register writes
    if (bus_i.wr) begin
      if (hit(bus_i.addr, STT_OFF_CTRL_STATUS)) begin
        state_next.enable   = bus_i.wdata[STT_BIT_ENABLE];
        state_next.tick_int = bus_i.wdata[STT_BIT_TICK_INT];
        state_next.clk_src  = bus_i.wdata[STT_BIT_CLK_SRC];
      end else if (hit(bus_i.addr, STT_OFF_RELOAD)) begin
        state_next.reload = bus_i.wdata[STT_CNT_W-1:0];
      end else if (hit(bus_i.addr, STT_OFF_CLK_SEL_0)) begin
        // reserved codes leave the field unchanged
        if (sel_ok(bus_i.wdata[STT_EXT_SEL_LSB +: STT_SEL_W])) begin
          state_next.ext_sel = bus_i.wdata[STT_EXT_SEL_LSB +: STT_SEL_W];
        end
        if (sel_ok(bus_i.wdata[STT_CORE_SEL_LSB +: STT_SEL_W])) begin
          state_next.core_sel = bus_i.wdata[STT_CORE_SEL_LSB +: STT_SEL_W];
        end
      end else if (hit(bus_i.addr, STT_OFF_IRQ_ENABLE)) begin
        state_next.irq_enable = bus_i.wdata[STT_BIT_IRQ_ZERO];
      end else if (hit(bus_i.addr, STT_OFF_IRQ_CLEAR)) begin
        // write one clears; same-cycle event wins below
        if (bus_i.wdata[STT_BIT_IRQ_ZERO]) begin
          state_next.irq_status = 1'b0;
        end
      end
    end

    // flag clears on read, a new zero event wins
    if (ctrl_rd) begin
      state_next.zero_flag = 1'b0;
    end
    if (zero_evt) begin
      state_next.zero_flag = 1'b1;
    end

    // sticky interrupt status, gated by the interrupt enable control
    if (zero_evt & state_reg.tick_int) begin
      state_next.irq_status = 1'b1;
    end

    // read data, presented in the cycle after the strobe
    state_next.rdata = 32'h00000000;
    if (bus_i.rd) begin
      if (hit(bus_i.addr, STT_OFF_CTRL_STATUS)) begin
        state_next.rdata[STT_BIT_ENABLE]    = state_reg.enable;
        state_next.rdata[STT_BIT_TICK_INT]  = state_reg.tick_int;
        state_next.rdata[STT_BIT_CLK_SRC]   = state_reg.clk_src;
        state_next.rdata[STT_BIT_ZERO_FLAG] = state_reg.zero_flag;
      end else if (hit(bus_i.addr, STT_OFF_RELOAD)) begin
        state_next.rdata[STT_CNT_W-1:0] = state_reg.reload;
      end else if (hit(bus_i.addr, STT_OFF_CURRENT)) begin
        state_next.rdata[STT_CNT_W-1:0] = state_reg.count;
      end else if (hit(bus_i.addr, STT_OFF_CLK_SEL_0)) begin
        state_next.rdata[STT_EXT_SEL_LSB +: STT_SEL_W]  = state_reg.ext_sel;
        state_next.rdata[STT_CORE_SEL_LSB +: STT_SEL_W] = state_reg.core_sel;
      end else if (hit(bus_i.addr, STT_OFF_IRQ_STATUS)) begin
        state_next.rdata[STT_BIT_IRQ_ZERO] = state_reg.irq_status;
      end else if (hit(bus_i.addr, STT_OFF_IRQ_ENABLE)) begin
        state_next.rdata[STT_BIT_IRQ_ZERO] = state_reg.irq_enable;
      end else begin
        // clear register and unmapped addresses read as zero
        state_next.rdata = 32'h00000000;
      end
    end
  end

  // state register; counter reset to zero though software must not rely on it
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= STT_STATE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs
  assign rdata_o             = state_reg.rdata;
  assign core_clock_select_o = state_reg.core_sel;
  assign count_o             = state_reg.count;
  assign irq_o               = state_reg.irq_status & state_reg.irq_enable;

  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // enabled tick decrements a nonzero count by one
  property p_count_dec;
    step && (state_reg.count != 24'h000000)
      |=> state_reg.count == $past(state_reg.count) - 24'h000001;
  endproperty
  a_count_dec: assert property (p_count_dec)
    else $error("count did not decrement by one");

  // any write to current value clears the count
  property p_write_clears;
    cur_wr |=> (state_reg.count == 24'h000000);
  endproperty
  a_write_clears: assert property (p_write_clears)
    else $error("current value write did not clear count");

  // zero reloads on the next tick
  property p_wrap;
    step && (state_reg.count == 24'h000000)
      |=> state_reg.count == $past(state_reg.reload);
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("count did not reload at zero");

  // reaching zero sets the flag, readable one read later
  property p_flag_set;
    zero_evt ##1 (bus_i.rd && hit(bus_i.addr, STT_OFF_CTRL_STATUS))
      |=> rdata_o[STT_BIT_ZERO_FLAG];
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("zero flag not set on reaching zero");

  // a read clears the flag unless a new event comes
  property p_flag_clear;
    ctrl_rd && !zero_evt |=> !state_reg.zero_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("zero flag not cleared by read");

  // zero reload keeps the counter at zero while enabled
  property p_zero_hold;
    (state_reg.reload == 24'h000000) && (state_reg.count == 24'h000000) && !cur_wr
      |=> (state_reg.count == 24'h000000) && !$rose(state_reg.zero_flag);
  endproperty
  a_zero_hold: assert property (p_zero_hold)
    else $error("count left zero with zero reload");

  // with the external source chosen, no edge means no step
  property p_ext_hold;
    !state_reg.clk_src && !(ext_level && !state_reg.ext_prev) && !cur_wr
      |=> $stable(state_reg.count);
  endproperty
  a_ext_hold: assert property (p_ext_hold)
    else $error("count moved without an external edge");

  // valid external select code reaches the selector
  property p_ext_sel;
    bus_i.wr && hit(bus_i.addr, STT_OFF_CLK_SEL_0)
      && (bus_i.wdata[5:3] < STT_SEL_LIMIT)
      |=> state_reg.ext_sel == $past(bus_i.wdata[5:3]);
  endproperty
  a_ext_sel: assert property (p_ext_sel)
    else $error("external select not taken");

  // valid core select code drives the output
  property p_core_sel;
    bus_i.wr && hit(bus_i.addr, STT_OFF_CLK_SEL_0)
      && (bus_i.wdata[2:0] < STT_SEL_LIMIT)
      |=> core_clock_select_o == $past(bus_i.wdata[2:0]);
  endproperty
  a_core_sel: assert property (p_core_sel)
    else $error("core select not taken");

  // enabled zero event raises the interrupt the next cycle
  property p_irq;
    zero_evt && state_reg.tick_int && state_reg.irq_enable
      && !(bus_i.wr && hit(bus_i.addr, STT_OFF_IRQ_ENABLE))
      |=> irq_o;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt not raised at zero");

  // a stopped counter keeps its value
  property p_count_idle;
    !state_reg.enable && !cur_wr
      |=> $stable(state_reg.count);
  endproperty
  a_count_idle: assert property (p_count_idle)
    else $error("count moved while disabled");

  // current value read returns the count of the strobe cycle
  property p_count_read;
    bus_i.rd && hit(bus_i.addr, STT_OFF_CURRENT)
      |=> rdata_o[STT_CNT_W-1:0] == $past(state_reg.count);
  endproperty
  a_count_read: assert property (p_count_read)
    else $error("current value read wrong");

  // reload write lands in full counter width
  property p_reload_write;
    bus_i.wr && hit(bus_i.addr, STT_OFF_RELOAD)
      |=> state_reg.reload == $past(bus_i.wdata[STT_CNT_W-1:0]);
  endproperty
  a_reload_write: assert property (p_reload_write)
    else $error("reload value not taken");

  // flag never rises without a transition to zero
  property p_flag_only_event;
    !state_reg.zero_flag && !zero_evt
      |=> !state_reg.zero_flag;
  endproperty
  a_flag_only_event: assert property (p_flag_only_event)
    else $error("zero flag set without reaching zero");

  // flag stays set until software reads it
  property p_flag_sticky;
    state_reg.zero_flag && !ctrl_rd
      |=> state_reg.zero_flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("zero flag lost without a read");

  // control read shows the flag as it stood before the clear
  property p_flag_read;
    ctrl_rd
      |=> rdata_o[STT_BIT_ZERO_FLAG] == $past(state_reg.zero_flag);
  endproperty
  a_flag_read: assert property (p_flag_read)
    else $error("zero flag read back wrong");

  // control write sets enable and clock source
  property p_ctrl_write;
    bus_i.wr && hit(bus_i.addr, STT_OFF_CTRL_STATUS)
      |=> (state_reg.enable == $past(bus_i.wdata[STT_BIT_ENABLE]))
          && (state_reg.clk_src == $past(bus_i.wdata[STT_BIT_CLK_SRC]));
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("control write not taken");

  // an external rising edge moves the count unless zero reload holds it
  property p_ext_tick;
    state_reg.enable && !state_reg.clk_src && ext_level && !state_reg.ext_prev && !cur_wr
      |=> $changed(state_reg.count) || (state_reg.count == 24'h000000);
  endproperty
  a_ext_tick: assert property (p_ext_tick)
    else $error("external edge did not step the count");

  // reserved external select codes leave the field alone
  property p_ext_reserved;
    bus_i.wr && hit(bus_i.addr, STT_OFF_CLK_SEL_0)
      && (bus_i.wdata[STT_EXT_SEL_LSB +: STT_SEL_W] >= STT_SEL_LIMIT)
      |=> $stable(state_reg.ext_sel);
  endproperty
  a_ext_reserved: assert property (p_ext_reserved)
    else $error("reserved external select taken");

  // reserved core select codes leave the field alone
  property p_core_reserved;
    bus_i.wr && hit(bus_i.addr, STT_OFF_CLK_SEL_0)
      && (bus_i.wdata[STT_CORE_SEL_LSB +: STT_SEL_W] >= STT_SEL_LIMIT)
      |=> $stable(core_clock_select_o);
  endproperty
  a_core_reserved: assert property (p_core_reserved)
    else $error("reserved core select taken");

  // status stays set until a clear write
  property p_irq_sticky;
    state_reg.irq_status
      && !(bus_i.wr && hit(bus_i.addr, STT_OFF_IRQ_CLEAR) && bus_i.wdata[STT_BIT_IRQ_ZERO])
      |=> state_reg.irq_status;
  endproperty
  a_irq_sticky: assert property (p_irq_sticky)
    else $error("interrupt status lost without clear");

  // clear write drops the status when no event competes
  property p_irq_clear;
    bus_i.wr && hit(bus_i.addr, STT_OFF_IRQ_CLEAR)
      && bus_i.wdata[STT_BIT_IRQ_ZERO] && !zero_evt
      |=> !state_reg.irq_status;
  endproperty
  a_irq_clear: assert property (p_irq_clear)
    else $error("interrupt status not cleared");

  // no status without an event under the interrupt enable control
  property p_irq_gate;
    !state_reg.irq_status && !(zero_evt && state_reg.tick_int)
      |=> !state_reg.irq_status;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt status set while gated");

endmodule : stt_system_tick_timer

// >>> verification/stt_tb.sv
// testbench: register-level self-checking tests of the system tick timer
module tb
  import stt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic                   clk_i;        // 100 MHz clock
  logic                   rst_i;        // async reset
  stt_bus_req_t           bus_i;        // register request
  logic [31:0]            rdata_o;      // read data
  logic [STT_NUM_SRC-1:0] ext_src_i;    // tick sources
  logic [STT_SEL_W-1:0]   core_sel_o;   // core clock select
  logic [STT_CNT_W-1:0]   count_o;      // current count
  logic                   irq_o;        // level interrupt
  logic [31:0]            exp_q[$];     // expected read data
  logic                   rd_seen;      // read taken at last edge
  int                     n_mismatch;   // mismatch count
  int                     check_count;  // comparison count
  logic [STT_CNT_W-1:0]   rel;          // random reload value
  logic [2:0]             core;         // random core select

  stt_system_tick_timer u_stt_system_tick_timer (
    .clk_i               (clk_i),
    .rst_i               (rst_i),
    .bus_i               (bus_i),
    .rdata_o             (rdata_o),
    .ext_src_i           (ext_src_i),
    .core_clock_select_o (core_sel_o),
    .count_o             (count_o),
    .irq_o               (irq_o)
  );

  // free-running clock
  initial clk_i = 1'h0;
  always #5 clk_i = ~clk_i;

  // compare one value, count and report
  task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
    check_count++;
    if (seen !== expv) begin
      n_mismatch++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask : chk

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    bus_i <= '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
    @(posedge clk_i);
    bus_i.wr <= 1'h0;
  endtask : wr

  // one-cycle read strobe, expectation queued
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    bus_i <= '{wr: 1'h0, rd: 1'h1, addr: a, wdata: $urandom};
    exp_q.push_back(e);
    @(posedge clk_i);
    bus_i.rd <= 1'h0;
  endtask : rd

  // drive tick sources: chosen line fixed, others random
  task automatic ext(input int s, input logic v);
    logic [STT_NUM_SRC-1:0] r;
    r = 5'($urandom);
    r[s] = v;
    @(posedge clk_i);
    ext_src_i <= r;
  endtask : ext

  // wait one edge, then look at the interrupt line
  task automatic irq_is(input logic v);
    @(posedge clk_i);
    #1;
    chk({31'h0, irq_o}, {31'h0, v});
  endtask : irq_is

  // print counts and verdict, end the run
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done

  // read monitor: data stands in the cycle after the strobe
  always @(posedge clk_i) begin
    rd_seen <= bus_i.rd;
  end
  always @(negedge clk_i) begin
    if (rd_seen === 1'h1) begin
      chk(rdata_o, exp_q.pop_front());
    end
  end

  // watchdog against a hang
  initial begin
    repeat (5000) @(posedge clk_i);
    n_mismatch++;
    test_done();
  end

  // main sequence
  initial begin
    bus_i = '0;
    ext_src_i = '0;
    rst_i = 1'h1;
    n_mismatch = 0;
    check_count = 0;
    void'($urandom(32'h414B0B10));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'h0;
    // reset values, write-only and unmapped places read zero
    for (int a = 0; a < 8; a++) begin
      rd(8'(a * 4), 32'h0);
    end
    chk({29'h0, core_sel_o}, 32'h0);
    // processor clock, reload of two, interrupt on
    wr(STT_OFF_RELOAD, 32'h2);
    wr(STT_OFF_CURRENT, $urandom);
    wr(STT_OFF_IRQ_ENABLE, 32'h1);
    wr(STT_OFF_CTRL_STATUS, 32'h7);
    for (int k = 0; k < 6; k++) begin
      @(posedge clk_i);
      #1;
      chk({8'h00, count_o}, 32'(2 - k % 3));
    end
    wr(STT_OFF_CTRL_STATUS, 32'h6);
    rd(STT_OFF_CTRL_STATUS, 32'h0001_0006);
    rd(STT_OFF_CTRL_STATUS, 32'h0000_0006);
    rd(STT_OFF_CURRENT, 32'h1);
    rd(STT_OFF_IRQ_STATUS, 32'h1);
    irq_is(1'h1);
    wr(STT_OFF_IRQ_ENABLE, 32'h0);
    irq_is(1'h0);
    wr(STT_OFF_IRQ_ENABLE, 32'h1);
    irq_is(1'h1);
    wr(STT_OFF_IRQ_CLEAR, 32'h1);
    irq_is(1'h0);
    rd(STT_OFF_IRQ_STATUS, 32'h0);
    wr(STT_OFF_CURRENT, 32'hFFFF_FFFF);
    rd(STT_OFF_CURRENT, 32'h0);
    // full-width reload, then a reload of zero
    wr(STT_OFF_RELOAD, 32'hFFFF_FFFF);
    wr(STT_OFF_CTRL_STATUS, 32'h5);
    @(posedge clk_i);
    @(posedge clk_i);
    #1;
    chk({8'h00, count_o}, 32'h00FF_FFFE);
    wr(STT_OFF_RELOAD, 32'h0);
    wr(STT_OFF_CURRENT, 32'h0);
    repeat (4) @(posedge clk_i);
    #1;
    chk({8'h00, count_o}, 32'h0);
    rd(STT_OFF_CTRL_STATUS, 32'h5);
    // external tick from each of the five sources
    for (int s = 0; s < STT_NUM_SRC; s++) begin
      rel = 24'($urandom_range(200, 5));
      core = 3'($urandom_range(4, 0));
      wr(STT_OFF_CTRL_STATUS, 32'h0);
      wr(STT_OFF_CLK_SEL_0, 32'({s[2:0], core}));
      wr(STT_OFF_RELOAD, 32'(rel));
      wr(STT_OFF_CURRENT, 32'h0);
      wr(STT_OFF_CTRL_STATUS, 32'h1);
      repeat (3) ext(s, 1'h0);
      #1;
      chk({8'h00, count_o}, 32'h0);
      repeat (3) begin
        ext(s, 1'h1);
        ext(s, 1'h0);
      end
      repeat (2) ext(s, 1'h0);
      #1;
      chk({8'h00, count_o}, 32'(rel - 24'h2));
      rd(STT_OFF_CLK_SEL_0, 32'({s[2:0], core}));
      chk({29'h0, core_sel_o}, 32'(core));
    end
    // reserved select codes leave both fields alone
    wr(STT_OFF_CLK_SEL_0, 32'h3E);
    rd(STT_OFF_CLK_SEL_0, 32'({3'h4, core}));
    repeat (2) @(posedge clk_i);
    chk(32'(exp_q.size()), 32'h0);
    test_done();
  end

endmodule : tb
